// ---- rtl/dmsn_consts.vh ----
// Shared constants of the dual MAC, store and negate datapath.
// Included by every design file of the block; holds definitions only.
`ifndef DMSN_CONSTS_VH
`define DMSN_CONSTS_VH
`define OFS_MODE 8'h00
`define OFS_STATUS 8'h04
`define OFS_REG_SEL 8'h08
`define OFS_REG_DATA 8'h0C
`define OFS_REG_EXT 8'h10
`define OFS_COEF_PTR 8'h14
`define MODE_RESET 8'h00
`define MB_FRACTIONAL 0
`define MB_WIDE_OVF 1
`define MB_ROUND 2
`define MB_DP_SAT 3
`define MB_AU_SAT 4
`define MB_SIGN_EXT 5
`define MB_LEGACY 6
`define MB_STORE_SAT 7
`define ST_CARRY 4
`define OPC_PAIR_BYTE 8'hFD
`define OPC_PAIR_FIELD 6'h17
`define OPC_STORE_BYTE 8'h87
`define OPC_STORE_FIELD 3'h2
`define OPC_NEG_FIELD 7'h1A
`define CMODE_POSTINC 2'h1
`define PTR_STEP 16'h0002
`define IDX_T2 4'h2
`define IDX_T3 4'h3
`define IDX_DPTR 4'h7
`define SAT40_POS 40'h7FFFFFFFFF
`define SAT40_NEG 40'h8000000000
`define SAT32_POS 40'h007FFFFFFF
`define SAT32_NEG 40'hFF80000000
`define SAT16_POS 16'h7FFF
`define SAT16_NEG 16'h8000
`define SAT16_UNS 16'hFFFF
`define ROUND_BIAS 41'h00000008000
`define ROUND_TIE 16'h8000
`define SHIFT_MAX16 16'h001F
`define SHIFT_MIN16 16'hFFE0
`define LEG_WRAP_LIM 6'h30
`define LEG_WRAP_ADD 7'h10
`endif

// ---- rtl/mac_unit.v ----
// One multiply-accumulate unit: extend, multiply, scale, add or subtract, round, saturate.
// Purely combinational; the caller registers the result in its execute cycle.
`include "dmsn_consts.vh"
module mac_unit (
   input wire [15:0] op_a_i,
   input wire [15:0] op_b_i,
   input wire uns_a_i,
   input wire uns_b_i,
   input wire [39:0] acc_i,
   input wire sub_i,
   input wire fractional_mode_bit_i,
   input wire rnd_i,
   input wire rdm_i,
   input wire m40_i,
   input wire datapath_saturate_bit_i,
   output wire [39:0] res_o,
   output wire ovf_o
);
   wire signed [16:0] ext_a = {~uns_a_i & op_a_i[15], op_a_i};
   wire signed [16:0] ext_b = {~uns_b_i & op_b_i[15], op_b_i};
   wire signed [33:0] prod_full = ext_a * ext_b;
   wire [31:0] prod = fractional_mode_bit_i ? {prod_full[30:0], 1'b0} : prod_full[31:0];
   wire [40:0] prod41 = {{9{prod[31]}}, prod};
   wire [40:0] acc41 = {acc_i[39], acc_i};
   wire [40:0] sum = sub_i ? acc41 - prod41 : acc41 + prod41;
   // Nearest-even mode keeps an exact tie on an even high half.
   wire tie_even = rdm_i & (sum[15:0] == `ROUND_TIE) & ~sum[16];
   wire [40:0] biased = tie_even ? sum : sum + `ROUND_BIAS;
   wire [40:0] rounded = rnd_i ? {biased[40:16], 16'h0000} : sum;
   wire ovf32 = ~((&rounded[40:31]) | ~(|rounded[40:31]));
   wire ovf40 = rounded[40] ^ rounded[39];
   wire [39:0] sat_val = m40_i ? (rounded[40] ? `SAT40_NEG : `SAT40_POS) :
                         (rounded[40] ? `SAT32_NEG : `SAT32_POS);
   assign ovf_o = m40_i ? ovf40 : ovf32;
   assign res_o = (datapath_saturate_bit_i & ovf_o) ? sat_val : rounded[39:0];
endmodule

// ---- rtl/acc_store_shifter.v ----
// Accumulator shifter for the parallel store: clamps the amount and yields the saturated high half.
// Purely combinational; amount comes from the shift amount register.
`include "dmsn_consts.vh"
module acc_store_shifter (
   input wire [39:0] acc_i,
   input wire [15:0] amount_i,
   input wire legacy_i,
   input wire sign_extend_mode_bit_i,
   input wire sst_i,
   output reg [15:0] hi_o
);
   reg [6:0] amt;
   reg [6:0] mag;
   reg [71:0] ext;
   reg [71:0] sh;
   reg sat;
   wire [15:0] max_amt = `SHIFT_MAX16;
   wire [15:0] min_amt = `SHIFT_MIN16;
   always @* begin
      if (legacy_i) begin
         if ($signed(amount_i[5:0]) < $signed(`LEG_WRAP_LIM)) begin
            amt = {amount_i[5], amount_i[5:0]} + `LEG_WRAP_ADD;
         end else begin
            amt = {amount_i[5], amount_i[5:0]};
         end
      end else if ($signed(amount_i) > $signed(`SHIFT_MAX16)) begin
         amt = max_amt[6:0];
      end else if ($signed(amount_i) < $signed(`SHIFT_MIN16)) begin
         amt = min_amt[6:0];
      end else begin
         amt = amount_i[6:0];
      end
      mag = 7'h00 - amt;
      ext = {{32{sign_extend_mode_bit_i & acc_i[39]}}, acc_i};
      if (amt[6]) begin
         sh = $signed(ext) >>> mag;
      end else begin
         sh = ext << amt[5:0];
      end
      // Signed values must fit 32 bits; unsigned ones must have nothing above bit 31.
      if (sign_extend_mode_bit_i) begin
         sat = ~((&sh[71:31]) | ~(|sh[71:31]));
      end else begin
         sat = |sh[71:32];
      end
      if (sst_i & sat) begin
         hi_o = sign_extend_mode_bit_i ? (sh[71] ? `SAT16_NEG : `SAT16_POS) : `SAT16_UNS;
      end else begin
         hi_o = sh[31:16];
      end
   end
endmodule

// ---- rtl/dual_mac_store_negate_datapath.v ----
// Execute datapath: paired long-operand multiply-subtract/accumulate, multiply-subtract with
// shifted store, and negate. Holds accumulators, temporaries, pointers and flags.
// Assumes an APB master, memories answering in the cycle fetch is high, and an issuing sequencer.
//
// The register addresses and the APB slave port were chosen for this implementation.
`include "dmsn_consts.vh"
// Operation
// - Paired op subtracts high product in second MAC, adds low product in first.
// - High data and high coefficient words come from the effective address, widened to 17.
// - Low words come from the partner address: plus one if even, minus one if odd.
// - Unsigned option zero-extends a word to 17 bits, otherwise it is sign-extended.
// - Fractional mode doubles each product before accumulation.
// - Product is sign-extended to 41 bits, then subtracted or added.
// - Accumulate half adds to its accumulator and writes back to that accumulator.
// - Rounding follows the round mode bit, only with the rounding option.
// - Overflow width follows wide-overflow mode; overflow sets the destination flag.
// - An overflowed accumulator saturates when datapath saturation is on.
// - Wide-overflow option acts as wide mode for one instruction only.
// - Paired op may post-decrement data pointer by two, post-increment coefficient pointer.
// - Paired op is decoded from a fixed four-byte pattern with option fields.
// - Store variant decoded from its byte pattern; multiplies temporary by memory word.
// - Store variant can copy its memory word into the operand copy register.
// - Store variant shifts another accumulator by the shift register, stores bits 31..16.
// - Shift amounts outside minus 32 to plus 31 clamp to the nearest limit.
// - Legacy mode uses six amount bits, folding minus 32..minus 17 up by 16.
// - Store-saturate saturates the stored half, unsigned unless sign-extension mode is set.
// - Negate writes the two's complement; carry marks a zero source: 40 bits in wide mode, else low 32, or 16 for registers.
// - Accumulator negate works on 40 bits with sign-extension and wide-overflow modes.
// - Register negate works on 16 bits, overflows at bit 15, saturates per address unit.
module dual_mac_store_negate_datapath (
   input wire mclk_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire issue_i,
   input wire [31:0] opcode_i,
   input wire [15:0] xmem_ea_i,
   input wire [15:0] ymem_ea_i,
   output reg issue_ready_o,
   output reg fetch_o,
   output reg [15:0] data_addr_hi_o,
   output reg [15:0] data_addr_lo_o,
   output reg [15:0] coef_addr_hi_o,
   output reg [15:0] coef_addr_lo_o,
   input wire [15:0] long_data_bus_i,
   input wire [15:0] second_data_bus_i,
   input wire [15:0] coef_high_bus_i,
   input wire [15:0] coef_low_bus_i,
   output reg store_o,
   output reg [15:0] store_addr_o,
   output reg [15:0] store_data_o,
   output reg [3:0] acc_ovf_o,
   output reg carry_o
);
   localparam K_NONE = 2'b00;
   localparam K_PAIR = 2'b01;
   localparam K_STORE = 2'b10;
   localparam K_NEG = 2'b11;

   // Low word of a long pair sits at the address with bit 0 flipped.
   function [15:0] partner_addr;
      input [15:0] ea;
      begin
         partner_addr = {ea[15:1], ~ea[0]};
      end
   endfunction

   function [39:0] widen16;
      input [15:0] v;
      input sx;
      begin
         widen16 = {{24{sx & v[15]}}, v};
      end
   endfunction

   reg [39:0] acc_reg [0:3];
   reg [15:0] gp_reg [0:11];
   reg [15:0] cptr_reg;
   reg [7:0] mode_reg;
   reg [3:0] sel_reg;
   reg [1:0] kind_reg;
   reg [31:0] op_reg;
   reg [15:0] yaddr_reg;
   integer i;

   wire fractional_mode_bit = mode_reg[`MB_FRACTIONAL];
   wire m40 = mode_reg[`MB_WIDE_OVF];
   wire round_mode_bit = mode_reg[`MB_ROUND];
   wire datapath_saturate_bit = mode_reg[`MB_DP_SAT];
   wire address_unit_saturate_bit = mode_reg[`MB_AU_SAT];
   wire sign_extend_mode_bit = mode_reg[`MB_SIGN_EXT];

   wire accept = issue_i & issue_ready_o;
   wire is_pair = (opcode_i[31:24] == `OPC_PAIR_BYTE) && (opcode_i[15:10] == `OPC_PAIR_FIELD);
   wire is_store = (opcode_i[31:24] == `OPC_STORE_BYTE) && (opcode_i[7:5] == `OPC_STORE_FIELD);
   wire is_neg = (opcode_i[31:25] == `OPC_NEG_FIELD);
   wire [15:0] dptr = gp_reg[`IDX_DPTR];

   wire apb_go = psel_i & penable_i & ~pready_o & (kind_reg == K_NONE) & ~accept;
   wire apb_wr = apb_go & pwrite_i;

   // Execute-cycle operand selection.
   wire k_pair = (kind_reg == K_PAIR);
   wire [1:0] sub_acc = k_pair ? op_reg[7:6] : op_reg[9:8];
   wire [1:0] add_acc = op_reg[5:4];
   wire [15:0] m2_a = k_pair ? long_data_bus_i : gp_reg[{2'b00, op_reg[11:10]}];
   wire [15:0] m2_b = k_pair ? coef_high_bus_i : second_data_bus_i;
   wire loc_m40 = m40 | (k_pair & op_reg[1]);
   wire [39:0] m2_res;
   wire m2_ovf;
   wire [39:0] m1_res;
   wire m1_ovf;
   wire [15:0] store_hi;

   mac_unit second_mult_acc_unit (
      .op_a_i(m2_a),
      .op_b_i(m2_b),
      .uns_a_i(k_pair & op_reg[3]),
      .uns_b_i(k_pair & op_reg[2]),
      .acc_i(acc_reg[sub_acc]),
      .sub_i(1'b1),
      .fractional_mode_bit_i(fractional_mode_bit),
      .rnd_i(op_reg[0]),
      .rdm_i(round_mode_bit),
      .m40_i(loc_m40),
      .datapath_saturate_bit_i(datapath_saturate_bit),
      .res_o(m2_res),
      .ovf_o(m2_ovf)
   );

   mac_unit first_mult_acc_unit (
      .op_a_i(second_data_bus_i),
      .op_b_i(coef_low_bus_i),
      .uns_a_i(op_reg[3]),
      .uns_b_i(op_reg[2]),
      .acc_i(acc_reg[add_acc]),
      .sub_i(1'b0),
      .fractional_mode_bit_i(fractional_mode_bit),
      .rnd_i(op_reg[0]),
      .rdm_i(round_mode_bit),
      .m40_i(loc_m40),
      .datapath_saturate_bit_i(datapath_saturate_bit),
      .res_o(m1_res),
      .ovf_o(m1_ovf)
   );

   acc_store_shifter store_shifter (
      .acc_i(acc_reg[op_reg[3:2]]),
      .amount_i(gp_reg[`IDX_T2]),
      .legacy_i(mode_reg[`MB_LEGACY]),
      .sign_extend_mode_bit_i(sign_extend_mode_bit),
      .sst_i(mode_reg[`MB_STORE_SAT]),
      .hi_o(store_hi)
   );

   // Negate: register ids 0..3 are accumulators, 4..15 index the 16-bit file.
   wire [3:0] nsrc = op_reg[23:20];
   wire [3:0] ndst = op_reg[19:16];
   wire src_is_acc = ~nsrc[3] & ~nsrc[2];
   wire dst_is_acc = ~ndst[3] & ~ndst[2];
   wire [3:0] src_gp = nsrc - 4'h4;
   wire [3:0] dst_gp = ndst - 4'h4;
   wire [39:0] nsrc40 = src_is_acc ? acc_reg[nsrc[1:0]] : widen16(gp_reg[src_gp], sign_extend_mode_bit);
   wire [15:0] nsrc16 = src_is_acc ? acc_reg[nsrc[1:0]][15:0] : gp_reg[src_gp];
   wire [40:0] neg41 = 41'h00000000000 - {nsrc40[39], nsrc40};
   wire nov40 = m40 ? (neg41[40] ^ neg41[39]) : ~((&neg41[40:31]) | ~(|neg41[40:31]));
   wire [39:0] nsat40 = m40 ? (neg41[40] ? `SAT40_NEG : `SAT40_POS) :
                        (neg41[40] ? `SAT32_NEG : `SAT32_POS);
   wire [39:0] nres40 = (nov40 & datapath_saturate_bit) ? nsat40 : neg41[39:0];
   wire ncarry40 = m40 ? (nsrc40 == 40'h0000000000) : (nsrc40[31:0] == 32'h00000000);
   wire [15:0] n16 = 16'h0000 - nsrc16;
   wire nov16 = (nsrc16 == `SAT16_NEG);
   wire [15:0] nres16 = (nov16 & address_unit_saturate_bit) ? `SAT16_POS : n16;
   wire ncarry = dst_is_acc ? ncarry40 : (nsrc16 == 16'h0000);

   // Status register view and its next value; a hardware set beats a software clear.
   reg [3:0] ovf_set;
   reg carry_set;
   reg carry_val;
   always @* begin
      ovf_set = 4'h0;
      carry_set = 1'b0;
      carry_val = 1'b0;
      if (k_pair) begin
         ovf_set[sub_acc] = m2_ovf;
         ovf_set[add_acc] = ovf_set[add_acc] | m1_ovf;
      end else if (kind_reg == K_STORE) begin
         ovf_set[sub_acc] = m2_ovf;
      end else if (kind_reg == K_NEG) begin
         carry_set = 1'b1;
         carry_val = ncarry;
         if (dst_is_acc) begin
            ovf_set[ndst[1:0]] = nov40;
         end
      end
   end

   wire st_clr = apb_wr & (paddr_i == `OFS_STATUS);
   wire [3:0] ovf_clr = st_clr ? pwdata_i[3:0] : 4'h0;
   wire carry_clr = st_clr & pwdata_i[`ST_CARRY];

   wire [39:0] sel_acc = acc_reg[sel_reg[1:0]];
   wire sel_is_acc = ~sel_reg[3] & ~sel_reg[2];
   wire [3:0] sel_gp = sel_reg - 4'h4;

   reg [31:0] rd_data;
   reg rd_err;
   always @* begin
      rd_data = 32'h00000000;
      rd_err = 1'b0;
      if (paddr_i == `OFS_MODE) begin
         rd_data = {24'h000000, mode_reg};
      end else if (paddr_i == `OFS_STATUS) begin
         rd_data = {27'h0000000, carry_o, acc_ovf_o};
      end else if (paddr_i == `OFS_REG_SEL) begin
         rd_data = {28'h0000000, sel_reg};
      end else if (paddr_i == `OFS_REG_DATA) begin
         rd_data = sel_is_acc ? sel_acc[31:0] : {16'h0000, gp_reg[sel_gp]};
      end else if (paddr_i == `OFS_REG_EXT) begin
         rd_data = sel_is_acc ? {24'h000000, sel_acc[39:32]} : 32'h00000000;
      end else if (paddr_i == `OFS_COEF_PTR) begin
         rd_data = {16'h0000, cptr_reg};
      end else begin
         rd_err = 1'b1;
      end
   end

   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            acc_reg[i] <= 40'h0000000000;
         end
         for (i = 0; i < 12; i = i + 1) begin
            gp_reg[i] <= 16'h0000;
         end
         cptr_reg <= 16'h0000;
         mode_reg <= `MODE_RESET;
         sel_reg <= 4'h0;
         kind_reg <= K_NONE;
         op_reg <= 32'h00000000;
         yaddr_reg <= 16'h0000;
         prdata_o <= 32'h00000000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         issue_ready_o <= 1'b0;
         fetch_o <= 1'b0;
         data_addr_hi_o <= 16'h0000;
         data_addr_lo_o <= 16'h0000;
         coef_addr_hi_o <= 16'h0000;
         coef_addr_lo_o <= 16'h0000;
         store_o <= 1'b0;
         store_addr_o <= 16'h0000;
         store_data_o <= 16'h0000;
         acc_ovf_o <= 4'h0;
         carry_o <= 1'b0;
      end else begin
         // Holding off issue while the bus is selected keeps register writes away from execution.
         issue_ready_o <= ~accept & ~psel_i;
         pready_o <= apb_go;
         pslverr_o <= apb_go & rd_err;
         if (apb_go & ~pwrite_i) begin
            prdata_o <= rd_data;
         end
         fetch_o <= 1'b0;
         store_o <= 1'b0;
         kind_reg <= K_NONE;
         if (accept) begin
            op_reg <= opcode_i;
            yaddr_reg <= ymem_ea_i;
            if (is_pair) begin
               kind_reg <= K_PAIR;
               fetch_o <= 1'b1;
               data_addr_hi_o <= dptr;
               coef_addr_hi_o <= cptr_reg;
               data_addr_lo_o <= partner_addr(dptr);
               coef_addr_lo_o <= partner_addr(cptr_reg);
            end else if (is_store) begin
               kind_reg <= K_STORE;
               fetch_o <= 1'b1;
               data_addr_lo_o <= xmem_ea_i;
            end else if (is_neg) begin
               kind_reg <= K_NEG;
            end
         end
         acc_ovf_o <= (acc_ovf_o & ~ovf_clr) | ovf_set;
         if (carry_set) begin
            carry_o <= carry_val;
         end else if (carry_clr) begin
            carry_o <= 1'b0;
         end
         case (kind_reg)
            K_PAIR: begin
               acc_reg[sub_acc] <= m2_res;
               acc_reg[add_acc] <= m1_res;
               if (op_reg[16]) begin
                  gp_reg[`IDX_DPTR] <= dptr - `PTR_STEP;
               end
               if (op_reg[9:8] == `CMODE_POSTINC) begin
                  cptr_reg <= cptr_reg + `PTR_STEP;
               end
            end
            K_STORE: begin
               acc_reg[sub_acc] <= m2_res;
               store_o <= 1'b1;
               store_addr_o <= yaddr_reg;
               store_data_o <= store_hi;
               if (op_reg[1]) begin
                  gp_reg[`IDX_T3] <= second_data_bus_i;
               end
            end
            K_NEG: begin
               if (dst_is_acc) begin
                  acc_reg[ndst[1:0]] <= nres40;
               end else begin
                  gp_reg[dst_gp] <= nres16;
               end
            end
            default: begin
               if (apb_wr) begin
                  if (paddr_i == `OFS_MODE) begin
                     mode_reg <= pwdata_i[7:0];
                  end else if (paddr_i == `OFS_REG_SEL) begin
                     sel_reg <= pwdata_i[3:0];
                  end else if (paddr_i == `OFS_REG_DATA) begin
                     if (sel_is_acc) begin
                        acc_reg[sel_reg[1:0]] <= {sel_acc[39:32], pwdata_i};
                     end else begin
                        gp_reg[sel_gp] <= pwdata_i[15:0];
                     end
                  end else if (paddr_i == `OFS_REG_EXT) begin
                     if (sel_is_acc) begin
                        acc_reg[sel_reg[1:0]] <= {pwdata_i[7:0], sel_acc[31:0]};
                     end
                  end else if (paddr_i == `OFS_COEF_PTR) begin
                     cptr_reg <= pwdata_i[15:0];
                  end
               end
            end
         endcase
      end
   end
endmodule

// ---- sim/dmsn_chk.sv ----
// Concurrent checks on the ports of the dual MAC, store and negate datapath.
// Assumes one clock domain and the bind at the foot of this file.
`include "dmsn_consts.vh"
module dmsn_chk (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic issue_i,
   input wire logic [31:0] opcode_i,
   input wire logic [15:0] ymem_ea_i,
   input wire logic issue_ready_o,
   input wire logic fetch_o,
   input wire logic [15:0] data_addr_hi_o,
   input wire logic [15:0] data_addr_lo_o,
   input wire logic [15:0] coef_addr_hi_o,
   input wire logic [15:0] coef_addr_lo_o,
   input wire logic store_o,
   input wire logic [15:0] store_addr_o,
   input wire logic [3:0] acc_ovf_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_take;
      issue_i && issue_ready_o;
   endsequence
   sequence s_pair_take;
      issue_i && issue_ready_o && opcode_i[31:24] == `OPC_PAIR_BYTE && opcode_i[15:10] == `OPC_PAIR_FIELD;
   endsequence
   sequence s_store_take;
      issue_i && issue_ready_o && opcode_i[31:24] == `OPC_STORE_BYTE && opcode_i[7:5] == `OPC_STORE_FIELD;
   endsequence
   a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("pready held too long");
   a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
   a_ready_after_access: assert property (pready_o |-> $past(psel_i && penable_i)) else $error("stray pready");
   a_issue_spacing: assert property (s_take |=> !issue_ready_o) else $error("issue accepted back to back");
   a_psel_blocks_issue: assert property (psel_i |=> !issue_ready_o) else $error("issue open during APB");
   a_fetch_cause: assert property (fetch_o |-> $past(issue_i && issue_ready_o)) else $error("fetch without issue");
   a_pair_partner: assert property (s_pair_take |=> fetch_o && coef_addr_lo_o == (coef_addr_hi_o ^ 16'h0001)
      && data_addr_lo_o == (data_addr_hi_o ^ 16'h0001)) else $error("partner address wrong");
   a_store_sequence: assert property (s_store_take |=> fetch_o ##1 store_o) else $error("store not in sequence");
   a_store_addr: assert property (store_o |-> store_addr_o == $past(ymem_ea_i, 2)) else $error("store address wrong");
   a_flag_clear: assert property ((($past(acc_ovf_o) & ~acc_ovf_o) != 4'h0) |->
      $past(psel_i && pwrite_i && paddr_i == `OFS_STATUS)) else $error("overflow flag dropped");
endmodule
bind dual_mac_store_negate_datapath dmsn_chk i_chk (.mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pready_o, .pslverr_o, .issue_i, .opcode_i, .ymem_ea_i, .issue_ready_o, .fetch_o, .data_addr_hi_o,
   .data_addr_lo_o, .coef_addr_hi_o, .coef_addr_lo_o, .store_o, .store_addr_o, .acc_ovf_o);

// ---- sim/mem_model.sv ----
// Data and coefficient memory that answers the datapath's fetches and takes its stores.
// Words are valid in the fetch cycle and the one after; otherwise the buses show inverted data.
module mem_model (
   input wire logic mclk_i,
   input wire logic fetch_i,
   input wire logic [15:0] da_hi_i,
   input wire logic [15:0] da_lo_i,
   input wire logic [15:0] ca_hi_i,
   input wire logic [15:0] ca_lo_i,
   input wire logic store_i,
   input wire logic [15:0] store_addr_i,
   input wire logic [15:0] store_data_i,
   output logic [15:0] ld_o,
   output logic [15:0] sd_o,
   output logic [15:0] ch_o,
   output logic [15:0] cl_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:65535];
   logic fetch_d = 1'b0;
   wire logic ok = fetch_i || fetch_d;
   always @(posedge mclk_i) begin
      fetch_d <= fetch_i;
      if (store_i)
         mem[store_addr_i] <= store_data_i;
   end
   assign ld_o = ok ? mem[da_hi_i] : ~mem[da_hi_i];
   assign sd_o = ok ? mem[da_lo_i] : ~mem[da_lo_i];
   assign ch_o = ok ? mem[ca_hi_i] : ~mem[ca_hi_i];
   assign cl_o = ok ? mem[ca_lo_i] : ~mem[ca_lo_i];
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the dual MAC, store and negate datapath.
// Drives APB and the issue port; a memory model serves fetches and stores.
`include "dmsn_consts.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, issue_i = 0, err;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, opcode_i = 32'h0, prdata_o, rd;
   logic [15:0] xmem_ea_i = 16'h0, ymem_ea_i = 16'h0, dah, dal, cah, cal, ldb, sdb, chb, clb, sta, std;
   logic pready_o, pslverr_o, issue_ready_o, fetch_o, store_o, carry_o;
   logic [3:0] acc_ovf_o;
   int num_errors = 0, cmp_count = 0;
   dual_mac_store_negate_datapath i_dut (.mclk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .issue_i, .opcode_i, .xmem_ea_i, .ymem_ea_i, .issue_ready_o, .fetch_o,
      .data_addr_hi_o(dah), .data_addr_lo_o(dal), .coef_addr_hi_o(cah), .coef_addr_lo_o(cal),
      .long_data_bus_i(ldb), .second_data_bus_i(sdb), .coef_high_bus_i(chb), .coef_low_bus_i(clb),
      .store_o, .store_addr_o(sta), .store_data_o(std), .acc_ovf_o, .carry_o);
   mem_model i_mem (.mclk_i, .fetch_i(fetch_o), .da_hi_i(dah), .da_lo_i(dal), .ca_hi_i(cah), .ca_lo_i(cal),
      .store_i(store_o), .store_addr_i(sta), .store_data_i(std), .ld_o(ldb), .sd_o(sdb), .ch_o(chb), .cl_o(clb));
   initial begin
      forever #25 mclk_i = ~mclk_i;
   end
   task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel_i <= 1;
      penable_i <= 0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1;
      do
         @(posedge mclk_i);
      while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task automatic wr(input logic [3:0] id, input logic [39:0] v);
      apb(1, `OFS_REG_SEL, {28'h0, id});
      apb(1, `OFS_REG_DATA, v[31:0]);
      if (id < 4)
         apb(1, `OFS_REG_EXT, {24'h0, v[39:32]});
   endtask
   task automatic chk(input logic [3:0] id, input logic [39:0] exp);
      apb(1, `OFS_REG_SEL, {28'h0, id});
      apb(0, `OFS_REG_DATA, 32'h0);
      cmp("register low word", exp[31:0], rd);
      if (id < 4) begin
         apb(0, `OFS_REG_EXT, 32'h0);
         cmp("accumulator guard byte", exp[39:32], rd);
      end
   endtask
   task automatic issue(input logic [31:0] op, input logic [15:0] xa, input logic [15:0] ya);
      @(posedge mclk_i);
      issue_i <= 1;
      opcode_i <= op;
      xmem_ea_i <= xa;
      ymem_ea_i <= ya;
      do
         @(posedge mclk_i);
      while (issue_ready_o !== 1'b1);
      issue_i <= 0;
      #1;
   endtask
   task automatic t_reset;
      apb(0, `OFS_MODE, 32'h0);
      cmp("mode reset", `MODE_RESET, rd);
      apb(0, `OFS_STATUS, 32'h0);
      cmp("status reset", 40'h0, rd);
      apb(1, 8'h40, 32'hFFFFFFFF);
      cmp("unmapped write error", 40'h1, err);
      apb(0, 8'h40, 32'h0);
      cmp("unmapped read data", 40'h0, rd);
      $display("test reset done");
   endtask
   task automatic t_pair;
      wr(0, 40'h0000008000);
      wr(1, 40'h0000008000);
      wr(11, 40'h10FE);
      apb(1, `OFS_COEF_PTR, 32'h2000);
      i_mem.mem[16'h10FE] = 16'hFF00;
      i_mem.mem[16'h10FF] = 16'hFE00;
      i_mem.mem[16'h2000] = 16'h8000;
      i_mem.mem[16'h2001] = 16'h4000;
      issue(32'hFD015D4C, 16'h0, 16'h0);
      cmp("data high address", 16'h10FE, dah);
      cmp("data low address", 16'h10FF, dal);
      cmp("coef high address", 16'h2000, cah);
      cmp("coef low address", 16'h2001, cal);
      chk(0, 40'h003F808000);
      chk(1, 40'hFF80808000);
      chk(11, 40'h10FC);
      apb(0, `OFS_COEF_PTR, 32'h0);
      cmp("coef pointer", 40'h2002, rd);
      cmp("no overflow", 40'h0, acc_ovf_o);
      $display("test pair done");
   endtask
   task automatic t_ovf;
      apb(1, `OFS_MODE, 32'h09);
      wr(0, 40'h007F000000);
      i_mem.mem[16'h10FC] = 16'h0000;
      i_mem.mem[16'h10FD] = 16'h4000;
      i_mem.mem[16'h2002] = 16'h0000;
      i_mem.mem[16'h2003] = 16'h4000;
      issue(32'hFD005C40, 16'h0, 16'h0);
      @(posedge mclk_i);
      #1;
      cmp("overflow flags", 40'h1, acc_ovf_o);
      chk(0, `SAT32_POS);
      apb(1, `OFS_STATUS, 32'h1F);
      cmp("flags after clear", 40'h0, acc_ovf_o);
      wr(0, 40'h007F00C000);
      issue(32'hFD005C43, 16'h0, 16'h0);
      chk(0, 40'h009F010000);
      cmp("local wide overflow flags", 40'h0, acc_ovf_o);
      apb(0, `OFS_MODE, 32'h0);
      cmp("mode kept", 40'h09, rd);
      apb(1, `OFS_MODE, 32'h0D);
      wr(0, 40'h007F008000);
      issue(32'hFD005C43, 16'h0, 16'h0);
      chk(0, 40'h009F000000);
      $display("test overflow done");
   endtask
   task automatic t_store(input logic [7:0] mode, input logic [39:0] acc, input logic [15:0] amt,
                          input logic [15:0] exp);
      apb(1, `OFS_MODE, {24'h0, mode});
      wr(2, acc);
      wr(3, 40'h10);
      wr(4, 40'h2);
      wr(6, {24'h0, amt});
      i_mem.mem[16'h0030] = 16'h0003;
      issue(32'h8700034A, 16'h0030, 16'h0031);
      cmp("xmem address", 16'h0030, dal);
      @(posedge mclk_i);
      #1;
      cmp("store strobe", 40'h1, store_o);
      cmp("stored high half", exp, std);
      chk(3, 40'h0A);
      chk(7, 40'h3);
      $display("test store done");
   endtask
   task automatic t_neg(input logic [3:0] src, input logic [3:0] dst, input logic [39:0] v,
                        input logic [7:0] mode, input logic [39:0] exp, input logic cy);
      apb(1, `OFS_MODE, {24'h0, mode});
      wr(src, v);
      issue({7'h1A, 1'b0, src, dst, 16'h0}, 16'h0, 16'h0);
      @(posedge mclk_i);
      #1;
      cmp("carry", cy, carry_o);
      chk(dst, exp);
      $display("test negate done");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1;
      t_reset();
      t_pair();
      t_ovf();
      t_store(8'h00, 40'h0000000001, 16'h0040, 16'h8000);
      t_store(8'h80, 40'h0000000003, 16'h0040, `SAT16_UNS);
      t_store(8'hA0, 40'h0000000003, 16'h0040, `SAT16_POS);
      t_store(8'h40, 40'h0040000000, 16'h0FE2, 16'h0001);
      t_neg(4, 1, 40'h2, 8'h00, 40'hFFFFFFFFFE, 1'b0);
      t_neg(5, 5, 40'h8000, 8'h10, 40'h7FFF, 1'b0);
      t_neg(2, 4, 40'h0, 8'h00, 40'h0, 1'b1);
      end_of_test();
   end
endmodule
